// file: logic/tbr_pkg.sv
/*
  Shared definitions of the trigger bus router: register offsets, field
  layouts, reset values, mode encodings and timing counts.
  Assumes a single 50 MHz system clock drives every user of it.
*/
`default_nettype none
package tbr_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000; // System clock rate
  localparam int CLK_NS = 20; // System clock period
  localparam int PULSE_NS = 100; // Least pulse width on a line
  // Least time rounds up, never below one cycle
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESYNC_HZ = 10; // Slow resync square wave
  localparam int RESYNC_HALF_CYC = CLK_HZ / (2 * RESYNC_HZ);
  localparam int OSC_HALF_CYC = 1; // Exported oscillator half period
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00; // Object configuration
  localparam logic [7:0] SKIP_ADDR = 8'h04; // edge_skip_count
  localparam logic [7:0] MARK_ADDR = 8'h08; // marker_pattern
  localparam logic [7:0] ROUTE_ADDR = 8'h0C; // Terminal routing
  localparam logic [7:0] ACT_ADDR = 8'h10; // output_action_command
  localparam logic [7:0] STAT_ADDR = 8'h14; // Status, write clears
  localparam logic [7:0] TS_ADDR = 8'h18; // Live timestamp
  localparam logic [31:0] SKIP_RST = 32'h0000_0000;
  localparam logic [31:0] MARK_RST = 32'h0000_0000;
  localparam logic [2:0] TB_LINE = 3'h7; // timebase_line index
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF, MODE_TS_IN, MODE_TX_IN, MODE_RX_OUT, MODE_TX_OUT,
    MODE_SW_OUT
  } tbr_mode_t; // trigger_mode_select
  typedef enum logic {
    SHAPE_PULSE, SHAPE_TOGGLE
  } tbr_shape_t; // output_shape_select
  typedef enum logic [2:0] {
    COMM_TX_CALL, COMM_TX_PERIODIC, COMM_TX_WAVE, COMM_RX_UNSOL,
    COMM_OTHER
  } tbr_comm_t; // Object communication type
  typedef enum logic [1:0] {
    TB_LOCAL, TB_BUS_LINE, TB_BACKPLANE
  } tbr_tb_t; // Timebase source
  // CTRL bits [0] open, [3:1] mode, [4] shape, [7:5] comm, [10:8] line
  typedef struct packed {
    logic [2:0] line;
    tbr_comm_t comm;
    tbr_shape_t shape;
    tbr_mode_t mode;
    logic open;
  } tbr_ctrl_t;
  // ROUTE bits [1:0] tb, [2] star, [3] osc export, [6:4] osc dest,
  // [7] resync export, [10:8] resync line
  typedef struct packed {
    logic [2:0] rs_line;
    logic rs_en;
    logic [2:0] osc_dest;
    logic osc_en;
    logic star;
    tbr_tb_t tb;
  } tbr_route_t;
  localparam tbr_ctrl_t CTRL_RST = '0;
  localparam tbr_route_t ROUTE_RST = '0;
  // Timestamp frame pushed to the receive queue
  typedef struct packed {
    logic [31:0] ts;
    logic [0:3][7:0] data; // data[0] is the marker's top byte
  } tbr_frame_t;
endpackage
`default_nettype wire

// file: logic/tbr_router.sv
/*
  Trigger bus router of one message object: edge-driven timestamp or
  transmit, output events on a bus line, timebase and resync routing.
  Assumes bus pins arrive asynchronously; queue handshakes come from
  logic on ref_clk_i.
*/
// Summary of operation
// - Rising input edge pushes timestamp frame
// - Frame carries four marker bytes
// - Receive-output mode: event per stored frame
// - Receive-output needs unsolicited reception
// - Transmit-output: event per sent frame
// - Software action command drives an event
// - Line select 0 to 6
// - Pulse lasts at least 100 ns
// - Toggle inverts present line level
// - Inputs see rising edges only
// - Skip count acts every N+1 edge
// - Marker top byte is payload byte 0
// - Line 7 imports local_oscillator_source
// - Star trigger accepted as source
// - Backplane clock usable as timebase
// - Oscillator exports only onto line 7
// - 10 Hz resync on lines 0-6
// - Send per counted edge, repeat if empty
`timescale 1ns/1ps
`default_nettype none
module tbr_router
  import tbr_pkg::*;
#(
  parameter int RESYNC_HALF = RESYNC_HALF_CYC // Shorten in simulation
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic [7:0] line_i,
  output logic [7:0] line_o,
  output logic [7:0] line_oe_o,
  input wire logic star_i,
  input wire logic clk10_i,
  input wire logic rx_stored_i,
  input wire logic tx_done_i,
  input wire logic wq_empty_i,
  output logic rx_push_o,
  output tbr_frame_t rx_frame_o,
  output logic tx_send_o,
  output logic tx_repeat_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tbr_ctrl_t ctrl_q; // Object configuration
  tbr_route_t route_q; // Terminal routing
  logic [31:0] skip_q; // Configured edge skip
  logic [31:0] mark_q; // Marker pattern
  logic [31:0] ts_q; // Timestamp counter
  logic [31:0] skip_cnt_q; // Edges still to skip
  logic [9:0] s1_q, s2_q; // Pin synchronisers
  logic src_prev_q; // Previous source level
  logic tb_prev_q; // Previous timebase level
  logic [2:0] pcnt_q; // Pulse width counter
  logic [7:0] obj_q; // Object drive level per line
  logic [31:0] rs_cnt_q; // Resync divider
  logic rs_q; // Resync square wave
  logic osc_q; // Exported oscillator
  logic cfg_err_q, route_err_q; // Rejected writes, sticky
  logic src_lvl, src_rise, act, tick, out_ev, is_in, is_out;
  logic ctrl_ok, route_ok;
  tbr_ctrl_t ctrl_w;
  tbr_route_t route_w;

  // Transmit types allowed for both transmit-driven modes
  function automatic logic tx_comm(input tbr_comm_t c);
    return c == COMM_TX_CALL || c == COMM_TX_PERIODIC ||
           c == COMM_TX_WAVE;
  endfunction

  // ----------------------------------------------------------------
  // Register writes and validation
  // ----------------------------------------------------------------
  assign ctrl_w = tbr_ctrl_t'(wr_data_i[10:0]);
  assign route_w = tbr_route_t'(wr_data_i[10:0]);
  // Mode needs a matching type and a general line
  always_comb begin
    ctrl_ok = ctrl_w.line <= 3'h6;
    case (ctrl_w.mode)
      MODE_RX_OUT: ctrl_ok = ctrl_ok && ctrl_w.comm == COMM_RX_UNSOL;
      MODE_TX_OUT, MODE_TX_IN: ctrl_ok = ctrl_ok && tx_comm(ctrl_w.comm);
      MODE_OFF, MODE_TS_IN, MODE_SW_OUT: ctrl_ok = ctrl_ok;
      default: ctrl_ok = 1'b0;
    endcase
  end
  // Oscillator only onto line 7, resync only on 0-6
  assign route_ok = (!route_w.osc_en || route_w.osc_dest == TB_LINE) &&
                    (!route_w.rs_en || route_w.rs_line != TB_LINE) &&
                    route_w.tb != 2'h3;

  // Configuration; a rejected write leaves the old setting in place
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      route_q <= ROUTE_RST;
      skip_q <= SKIP_RST;
      mark_q <= MARK_RST;
    end else if (wr_i) begin
      case (addr_i)
        CTRL_ADDR: if (ctrl_ok) ctrl_q <= ctrl_w;
        ROUTE_ADDR: if (route_ok) route_q <= route_w;
        SKIP_ADDR: skip_q <= wr_data_i;
        MARK_ADDR: mark_q <= wr_data_i;
        default: ;
      endcase
    end
  end

  // Sticky reject flags; a new reject wins over the clearing write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_err_q <= 1'b0;
      route_err_q <= 1'b0;
    end else begin
      cfg_err_q <= (wr_i && addr_i == CTRL_ADDR && !ctrl_ok) ||
                   (cfg_err_q && !(wr_i && addr_i == STAT_ADDR));
      route_err_q <= (wr_i && addr_i == ROUTE_ADDR && !route_ok) ||
                     (route_err_q && !(wr_i && addr_i == STAT_ADDR));
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        CTRL_ADDR: rd_data_o <= {21'h000000, ctrl_q};
        ROUTE_ADDR: rd_data_o <= {21'h000000, route_q};
        SKIP_ADDR: rd_data_o <= skip_q;
        MARK_ADDR: rd_data_o <= mark_q;
        STAT_ADDR: rd_data_o <= {29'h00000000, src_lvl, route_err_q,
                                 cfg_err_q};
        TS_ADDR: rd_data_o <= ts_q;
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------------------------------
  // Only the second stage is read by logic
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
    end else begin
      s1_q <= {clk10_i, star_i, line_i};
      s2_q <= s1_q;
    end
  end
  // Star trigger replaces the bus line as the source
  assign src_lvl = route_q.star ? s2_q[8] : s2_q[ctrl_q.line];
  assign is_in = ctrl_q.open &&
                 (ctrl_q.mode == MODE_TS_IN || ctrl_q.mode == MODE_TX_IN);
  assign is_out = ctrl_q.open && (ctrl_q.mode == MODE_RX_OUT ||
                  ctrl_q.mode == MODE_TX_OUT || ctrl_q.mode == MODE_SW_OUT);
  // Rising edges only, shape setting not consulted
  assign src_rise = is_in && src_lvl && !src_prev_q;
  assign act = src_rise && skip_cnt_q == 32'h0000_0000;

  // Previous levels for edge finding
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_q <= 1'b0;
      tb_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
      tb_prev_q <= route_q.tb == TB_BACKPLANE ? s2_q[9] : s2_q[7];
    end
  end

  // Skip counter: empty while closed, so the first edge acts
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      skip_cnt_q <= 32'h0000_0000;
    end else if (!ctrl_q.open) begin
      skip_cnt_q <= 32'h0000_0000;
    end else if (act) begin
      skip_cnt_q <= skip_q;
    end else if (src_rise) begin
      skip_cnt_q <= skip_cnt_q - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Timebase and timestamp
  // ----------------------------------------------------------------
  // An imported timebase is sampled; its rate must stay below half of
  // the system clock, so a 20 MHz import is only seen at 50 MHz
  // as long as duty stays near even.
  always_comb begin
    case (route_q.tb)
      TB_BUS_LINE: tick = s2_q[7] && !tb_prev_q;
      TB_BACKPLANE: tick = s2_q[9] && !tb_prev_q;
      default: tick = 1'b1;
    endcase
  end
  // Free-running count of timebase ticks
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) ts_q <= 32'h0000_0000;
    else if (tick) ts_q <= ts_q + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Queue side: timestamp frames and edge-driven sends
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_push_o <= 1'b0;
      rx_frame_o <= '0;
      tx_send_o <= 1'b0;
      tx_repeat_o <= 1'b0;
    end else begin
      rx_push_o <= act && ctrl_q.mode == MODE_TS_IN;
      tx_send_o <= act && ctrl_q.mode == MODE_TX_IN;
      if (act) begin
        tx_repeat_o <= wq_empty_i;
        rx_frame_o.ts <= ts_q;
        rx_frame_o.data <= mark_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output events on the selected line
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_q.mode)
      MODE_RX_OUT: out_ev = rx_stored_i;
      MODE_TX_OUT: out_ev = tx_done_i;
      MODE_SW_OUT: out_ev = wr_i && addr_i == ACT_ADDR;
      default: out_ev = 1'b0;
    endcase
    out_ev = out_ev && ctrl_q.open;
  end

  // Pulse restarts its full width on each event
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      obj_q <= 8'h00;
      pcnt_q <= 3'h0;
    end else if (out_ev && ctrl_q.shape == SHAPE_TOGGLE) begin
      obj_q[ctrl_q.line] <= !obj_q[ctrl_q.line];
    end else if (out_ev) begin
      obj_q[ctrl_q.line] <= 1'b1;
      pcnt_q <= 3'(PULSE_CYC - 1);
    end else if (ctrl_q.shape == SHAPE_PULSE) begin
      if (pcnt_q != 3'h0) pcnt_q <= pcnt_q - 3'h1;
      else obj_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Exported clocks
  // ----------------------------------------------------------------
  // Slow 50 percent square wave for partner realignment
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_cnt_q <= 32'h0000_0000;
      rs_q <= 1'b0;
    end else if (rs_cnt_q >= 32'(RESYNC_HALF - 1)) begin
      rs_cnt_q <= 32'h0000_0000;
      rs_q <= !rs_q;
    end else begin
      rs_cnt_q <= rs_cnt_q + 32'h0000_0001;
    end
  end
  // Local oscillator stand-in, toggled every cycle while OSC_HALF_CYC is 1, held low otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) osc_q <= 1'b0;
    else if (OSC_HALF_CYC == 1) osc_q <= !osc_q;
  end

  // Per-line drive: object first, then resync, then oscillator
  for (genvar i = 0; i < 8; i++) begin : g_line
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        line_o[i] <= 1'b0;
        line_oe_o[i] <= 1'b0;
      end else if (is_out && ctrl_q.line == 3'(i)) begin
        line_o[i] <= obj_q[i];
        line_oe_o[i] <= 1'b1;
      end else if (route_q.rs_en && route_q.rs_line == 3'(i)) begin
        line_o[i] <= rs_q;
        line_oe_o[i] <= 1'b1;
      end else if (route_q.osc_en && i == 7) begin
        line_o[i] <= osc_q;
        line_oe_o[i] <= 1'b1;
      end else begin
        line_o[i] <= 1'b0;
        line_oe_o[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_ts_capture: assert property (act && ctrl_q.mode == MODE_TS_IN
    |=> rx_push_o && rx_frame_o.ts == $past(ts_q)) else $error("ts");
  a_marker_order: assert property (rx_push_o |->
    rx_frame_o.data[0] == $past(mark_q[31:24], 1) &&
    rx_frame_o.data[3] == $past(mark_q[7:0], 1)) else $error("marker");
  a_rx_reject: assert property (wr_i && addr_i == CTRL_ADDR &&
    ctrl_w.mode == MODE_RX_OUT && ctrl_w.comm != COMM_RX_UNSOL
    |=> $stable(ctrl_q) && cfg_err_q) else $error("rx reject");
  a_event_drive: assert property (out_ev && ctrl_q.shape ==
    SHAPE_PULSE && !(wr_i && addr_i == CTRL_ADDR)
    |=> ##1 line_o[ctrl_q.line] && line_oe_o[ctrl_q.line])
    else $error("event");
  a_pulse_width: assert property ($rose(obj_q[ctrl_q.line]) &&
    ctrl_q.shape == SHAPE_PULSE |-> obj_q[ctrl_q.line] [*5])
    else $error("pulse");
  a_toggle_flip: assert property (out_ev && ctrl_q.shape ==
    SHAPE_TOGGLE |=> obj_q[$past(ctrl_q.line)] !=
    $past(obj_q[ctrl_q.line])) else $error("toggle");
  a_skip_hold: assert property (src_rise && skip_cnt_q != 0
    |=> !rx_push_o && !tx_send_o) else $error("skip");
  a_osc_reject: assert property (wr_i && addr_i == ROUTE_ADDR &&
    route_w.osc_en && route_w.osc_dest != TB_LINE |=> $stable(route_q))
    else $error("osc reject");
  a_send_edge: assert property (act && ctrl_q.mode == MODE_TX_IN
    |=> tx_send_o && tx_repeat_o == $past(wq_empty_i)) else $error("tx");
  c_ts_frame: cover property (rx_push_o);
  c_tx_send: cover property (tx_send_o && tx_repeat_o);
  c_toggle: cover property (out_ev && ctrl_q.shape == SHAPE_TOGGLE);
  c_resync: cover property (route_q.rs_en && $rose(rs_q));
endmodule
`default_nettype wire

// file: verif/tbr_card_model.sv
/*
  Model of another card on the trigger bus: pulses lines or the star pin
  and runs the bus timebases. Assumes the bench merges this drive with
  the router's own line drive.
*/
`timescale 1ns/1ps
`default_nettype none
module tbr_card_model (
  input wire logic rs_i,
  output var logic [7:0] drv_o,
  output var logic star_o,
  output var logic clk10_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  logic tb_run; // Line 7 timebase runs
  logic bp_run; // Backplane clock runs
  int realign_cnt = 0; // Local timebase realignments
  initial begin
    drv_o = 8'h00;
    star_o = 1'b0;
    clk10_o = 1'b0;
    tb_run = 1'b0;
    bp_run = 1'b0;
  end
  // Index 8 means the star pin; 60 ns high and low, off clock edges
  // Bursts stay short, never a sustained fast rate
  task automatic pulse(input int idx, input int n);
    #7;
    repeat (n) begin
      if (idx > 7) star_o = 1'b1;
      else drv_o[idx] = 1'b1;
      #60;
      if (idx > 7) star_o = 1'b0;
      else drv_o[idx] = 1'b0;
      #60;
    end
  endtask
  // Imported timebase on line 7, 160 ns period
  always #80 if (tb_run) drv_o[7] = ~drv_o[7];
  // Backplane clock, 100 ns period
  always #50 if (bp_run) clk10_o = ~clk10_o;
  // Local timebase snaps into step on each resync rise
  always @(posedge rs_i) realign_cnt++;
endmodule
`default_nettype wire

// file: verif/tbr_router_bench.sv
/*
  Self-checking bench of the trigger bus router: register port, input
  edge modes, output events and terminal routing.
  Assumes the card model drives every line the router leaves free.
*/
`timescale 1ns/1ps
`default_nettype none
module tbr_router_bench;
  import tbr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int RS_HALF = 8; // Short resync half period
  logic ref_clk_i, rst_i, wr_i, rd_i, rx_stored_i, tx_done_i, wq_empty_i;
  logic [7:0] addr_i, line_o, line_oe_o, card_drv;
  logic [31:0] wr_data_i, rd_data_o;
  logic star, clk10, rx_push_o, tx_send_o, tx_repeat_o;
  tbr_frame_t rx_frame_o, last_frame; // Last pushed frame
  logic [31:0] ts_list [$]; // Timestamps of pushes
  int miscompares = 0;
  int num_checks = 0;
  int push_cnt = 0;
  int send_cnt = 0;
  // Router wins a line it enables, card drives the rest
  wire [7:0] line_w = (line_oe_o & line_o) | (~line_oe_o & card_drv);
  tbr_router #(.RESYNC_HALF(RS_HALF)) dut_u (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .line_i(line_w),
    .line_o(line_o), .line_oe_o(line_oe_o), .star_i(star),
    .clk10_i(clk10), .rx_stored_i(rx_stored_i), .tx_done_i(tx_done_i),
    .wq_empty_i(wq_empty_i), .rx_push_o(rx_push_o),
    .rx_frame_o(rx_frame_o), .tx_send_o(tx_send_o),
    .tx_repeat_o(tx_repeat_o));
  tbr_card_model card_u (.rs_i(line_w[1]), .drv_o(card_drv), .star_o(star),
    .clk10_o(clk10));
  always #10 ref_clk_i = ~ref_clk_i;
  // Record pushes and sends as they stand
  always @(posedge ref_clk_i) begin
    if (rx_push_o === 1'b1) begin
      push_cnt++;
      last_frame = rx_frame_o;
      ts_list.push_back(rx_frame_o.ts);
    end
    if (tx_send_o === 1'b1) send_cnt++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  // Open object word from its fields
  function automatic logic [31:0] cw(tbr_mode_t m, tbr_comm_t c,
      tbr_shape_t s, logic [2:0] l);
    return {21'h0, tbr_ctrl_t'{l, c, s, m, 1'b1}};
  endfunction
  // One-cycle strobe on tx_done_i (tx set) or rx_stored_i
  task automatic strobe(input bit tx);
    @(posedge ref_clk_i);
    if (tx) tx_done_i <= 1'b1;
    else rx_stored_i <= 1'b1;
    @(posedge ref_clk_i);
    tx_done_i <= 1'b0;
    rx_stored_i <= 1'b0;
  endtask
  // High cycles and longest high run of a driven line
  task automatic hi_run(input int idx, input int cyc, output int n,
      output int m);
    int r;
    n = 0;
    m = 0;
    r = 0;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if (line_o[idx] === 1'b1 && line_oe_o[idx] === 1'b1) begin
        n++;
        r++;
      end else r = 0;
      if (r > m) m = r;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [7:0] a [6];
    a = '{CTRL_ADDR, SKIP_ADDR, MARK_ADDR, ROUTE_ADDR, STAT_ADDR, 8'h40};
    foreach (a[i]) begin
      rd(a[i], d);
      chk(d, 32'h0);
    end
    wr(MARK_ADDR, 32'hAABBCCDD);
    rd(MARK_ADDR, d);
    chk(d, 32'hAABBCCDD);
  endtask
  // Skip of two acts on edges one and four; toggle shape is ignored
  task automatic t_ts_skip();
    int p0;
    wr(SKIP_ADDR, 32'h2);
    wr(CTRL_ADDR, cw(MODE_TS_IN, COMM_RX_UNSOL, SHAPE_TOGGLE, 3'h2));
    p0 = push_cnt;
    card_u.pulse(2, 4);
    repeat (6) @(posedge ref_clk_i);
    chk(push_cnt - p0, 2);
    chk(ts_list[$] - ts_list[$-1], 18);
    chk(last_frame.data, 32'hAABBCCDD);
    chk(last_frame.data[0], 8'hAA);
    wr(SKIP_ADDR, 32'h0);
    wr(ROUTE_ADDR, 32'h4);
    p0 = push_cnt;
    // Counter still holds the old skip of two; zero loads after the act
    card_u.pulse(8, 3);
    repeat (6) @(posedge ref_clk_i);
    chk(push_cnt - p0, 1);
    wr(ROUTE_ADDR, 32'h0);
  endtask
  // Send per edge; repeat flag follows the empty queue
  task automatic t_tx_in();
    int s0;
    s0 = send_cnt;
    wq_empty_i <= 1'b1;
    wr(CTRL_ADDR, cw(MODE_TX_IN, COMM_TX_CALL, SHAPE_PULSE, 3'h3));
    card_u.pulse(3, 1);
    repeat (6) @(posedge ref_clk_i);
    chk(tx_repeat_o, 1);
    wq_empty_i <= 1'b0;
    card_u.pulse(3, 1);
    repeat (6) @(posedge ref_clk_i);
    chk(tx_repeat_o, 0);
    chk(send_cnt - s0, 2);
  endtask
  // Output events in pulse and toggle shape, and refused configs
  task automatic t_out();
    int n, m;
    logic [31:0] d;
    logic v;
    wr(CTRL_ADDR, cw(MODE_RX_OUT, COMM_RX_UNSOL, SHAPE_PULSE, 3'h4));
    strobe(1'b0);
    hi_run(4, 20, n, m);
    chk(n, PULSE_CYC);
    wr(CTRL_ADDR, cw(MODE_RX_OUT, COMM_TX_CALL, SHAPE_PULSE, 3'h4));
    rd(STAT_ADDR, d);
    chk(d[0], 1);
    rd(CTRL_ADDR, d);
    chk(d, cw(MODE_RX_OUT, COMM_RX_UNSOL, SHAPE_PULSE, 3'h4));
    wr(STAT_ADDR, 32'h0);
    wr(CTRL_ADDR, cw(MODE_SW_OUT, COMM_OTHER, SHAPE_PULSE, 3'h7));
    rd(STAT_ADDR, d);
    chk(d[0], 1);
    wr(CTRL_ADDR, cw(MODE_SW_OUT, COMM_OTHER, SHAPE_PULSE, 3'h6));
    wr(ACT_ADDR, 32'h1);
    hi_run(6, 20, n, m);
    chk(m, PULSE_CYC);
    wr(CTRL_ADDR, cw(MODE_TX_OUT, COMM_TX_WAVE, SHAPE_TOGGLE, 3'h5));
    repeat (3) @(posedge ref_clk_i);
    repeat (2) begin
      v = line_o[5];
      strobe(1'b1);
      repeat (3) @(posedge ref_clk_i);
      chk(line_o[5], !v);
    end
    wr(CTRL_ADDR, 32'h0);
  endtask
  // Oscillator export, resync wave and refused destinations
  task automatic t_route();
    int n, m, r0;
    logic [31:0] d;
    wr(STAT_ADDR, 32'h0);
    wr(ROUTE_ADDR, 32'h78);
    hi_run(7, 32, n, m);
    chk(m, 1);
    chk(n, 16);
    wr(ROUTE_ADDR, 32'h38);
    rd(STAT_ADDR, d);
    chk(d[1], 1);
    wr(STAT_ADDR, 32'h0);
    wr(ROUTE_ADDR, 32'h180);
    hi_run(1, 4 * RS_HALF, n, m);
    chk(m, RS_HALF);
    chk(n, 2 * RS_HALF);
    // Wave is settled now; two full periods give two partner realigns
    r0 = card_u.realign_cnt;
    repeat (4 * RS_HALF) @(posedge ref_clk_i);
    #1;
    chk(card_u.realign_cnt - r0, 2);
    wr(ROUTE_ADDR, 32'h780);
    rd(STAT_ADDR, d);
    chk(d[1], 1);
    wr(ROUTE_ADDR, 32'h0);
  endtask
  // Timestamp counts edges of the imported timebase
  task automatic tb_rate(input logic [31:0] r, input int lo, input int hi);
    logic [31:0] t0, t1;
    wr(ROUTE_ADDR, r);
    rd(TS_ADDR, t0);
    repeat (80) @(posedge ref_clk_i);
    rd(TS_ADDR, t1);
    chk((t1 - t0 >= lo) && (t1 - t0 <= hi), 1);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    rst_i = 1'b1;
    {wr_i, rd_i, rx_stored_i, tx_done_i, wq_empty_i} = 5'h00;
    addr_i = 8'h00;
    wr_data_i = 32'h0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_regs();
    t_ts_skip();
    t_tx_in();
    t_out();
    t_route();
    card_u.tb_run = 1'b1;
    tb_rate(32'h1, 9, 11);
    card_u.bp_run = 1'b1;
    tb_rate(32'h2, 15, 17);
    end_of_test();
  end
  initial begin
    #1500000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
